// [src/tspi_top.sv]
`timescale 1ns/100ps

module tspi_fifo import tspi_pkg::*; #(
  parameter int WIDTH = LANE_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             core_clk_in,
  input  wire logic             srst_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic [WIDTH-1:0]      rd_data_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("tspi_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_count;
  logic             next_wr_ready;
  logic             push;
  logic             pop;

  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_ready_in && rd_valid_out;
  assign rd_valid_out = (count != '0);
  assign rd_data_out  = mem[rd_ptr];

  always_comb begin
    next_wr_ptr   = push ? AW'(wr_ptr + AW'(1)) : wr_ptr;
    next_rd_ptr   = pop ? AW'(rd_ptr + AW'(1)) : rd_ptr;
    next_count    = CW'(count + CW'(push) - CW'(pop));
    // Ready is a flop so the source sees full without a combinational path
    next_wr_ready = (next_count != CW'(DEPTH));
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      wr_ptr       <= '0;
      rd_ptr       <= '0;
      count        <= '0;
      wr_ready_out <= 1'b0;
    end else begin
      wr_ptr       <= next_wr_ptr;
      rd_ptr       <= next_rd_ptr;
      count        <= next_count;
      wr_ready_out <= next_wr_ready;
    end
  end

  // Storage has no reset; only entries below count are ever read
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem[wr_ptr] <= wr_data_in;
    end
  end
endmodule // tspi_fifo

// How it works
// - End-of-packet is looked at only when the segment's valid is high.
// - Error is taken only with valid and end-of-packet both high.
// - An errored end replaces the last data word with the error control word.
// - An errored packet has frame check disabled for that packet alone.
// - Empty count is taken only with valid and end-of-packet high.
// - Errored end forces the low three empty-count bits to zero.
// - Errored end still passes the top empty-count bit unchanged.
// - Four segments, each with its own end, error and empty count.
// - No control is taken from a segment whose valid is low; its payload still passes through.
// - Each segment carries one 128-bit word per clock, four per cycle.
module tspi_top import tspi_pkg::*; #(
  parameter int SEG_COUNT = SEG_NUM,
  parameter int BUF_DEPTH = FIFO_DEPTH
) (
  input  wire logic                                core_clk_in,
  input  wire logic                                srst_in,
  input  wire logic [SEG_COUNT-1:0]                seg_valid_in,
  input  wire logic [SEG_COUNT-1:0]                seg_start_of_packet_in,
  input  wire logic [SEG_COUNT-1:0]                seg_end_of_packet_in,
  input  wire logic [SEG_COUNT-1:0]                seg_packet_error_in,
  input  wire logic [SEG_COUNT-1:0][SEG_MTY_W-1:0]  seg_empty_byte_count_in,
  input  wire logic [SEG_COUNT-1:0][SEG_DATA_W-1:0] seg_payload_in,
  output logic                                     seg_ready_out,
  input  wire logic                                lane_ready_in,
  output logic                                     lane_word_valid_out,
  output logic [SEG_COUNT-1:0]                     lane_valid_out,
  output logic [SEG_COUNT-1:0]                     lane_start_out,
  output logic [SEG_COUNT-1:0]                     lane_end_out,
  output logic [SEG_COUNT-1:0]                     lane_err_word_out,
  output logic [SEG_COUNT-1:0]                     lane_fcs_check_en_out,
  output logic [SEG_COUNT-1:0][SEG_MTY_W-1:0]       lane_empty_out,
  output logic [SEG_COUNT-1:0][SEG_DATA_W-1:0]      lane_payload_out
);
  localparam int WORD_W = SEG_COUNT * LANE_W;

  if (SEG_COUNT < 1) begin : g_bad_segs
    $error("tspi_top needs at least one segment");
  end

  logic [SEG_COUNT-1:0]                q_sop;
  logic [SEG_COUNT-1:0]                q_eop;
  logic [SEG_COUNT-1:0]                q_err;
  logic [SEG_COUNT-1:0][SEG_MTY_W-1:0]  q_mty;
  logic [SEG_COUNT-1:0][SEG_DATA_W-1:0] q_payload;
  logic [WORD_W-1:0]                   in_word;
  logic                                in_any;
  logic                                fifo_valid;
  logic [WORD_W-1:0]                   fifo_word;
  logic                                take;
  logic                                out_valid;
  logic [WORD_W-1:0]                   out_word;
  logic                                next_out_valid;
  logic [WORD_W-1:0]                   next_out_word;

  // Independent qualification per segment
  for (genvar s = 0; s < SEG_COUNT; s++) begin : g_seg
    assign q_sop[s] = seg_valid_in[s] && seg_start_of_packet_in[s];
    assign q_eop[s] = seg_valid_in[s] && seg_end_of_packet_in[s];
    assign q_err[s] = q_eop[s] && seg_packet_error_in[s];
    // Middle transfers report no empty bytes whatever the source drives
    assign q_mty[s] = !q_eop[s] ? MTY_NONE :
                      q_err[s] ? (seg_empty_byte_count_in[s] & MTY_ERR_MASK) :
                      seg_empty_byte_count_in[s];
    // The whole last word is corrupted so the far end must see the error
    assign q_payload[s] = q_err[s] ? ERR_WORD : seg_payload_in[s];

    assign in_word[s*LANE_W +: LANE_W] = {
      q_eop[s] && !q_err[s],
      q_err[s], q_eop[s], q_sop[s], seg_valid_in[s], q_mty[s], q_payload[s]};

    assign lane_payload_out[s]      = out_word[s*LANE_W + FLD_PAYLOAD +: SEG_DATA_W];
    assign lane_empty_out[s]        = out_word[s*LANE_W + FLD_MTY +: SEG_MTY_W];
    assign lane_valid_out[s]        = out_word[s*LANE_W + FLD_VALID];
    assign lane_start_out[s]        = out_word[s*LANE_W + FLD_SOP];
    assign lane_end_out[s]          = out_word[s*LANE_W + FLD_EOP];
    assign lane_err_word_out[s]     = out_word[s*LANE_W + FLD_ERR];
    assign lane_fcs_check_en_out[s] = out_word[s*LANE_W + FLD_FCS_EN];
  end

  // A cycle with no valid segment carries nothing and is not stored
  assign in_any = |seg_valid_in;

  // Source must hold its transfer while ready is low; nothing is dropped
  tspi_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (BUF_DEPTH)
  ) u_fifo (
    .core_clk_in  (core_clk_in),
    .srst_in      (srst_in),
    .wr_valid_in  (in_any),
    .wr_ready_out (seg_ready_out),
    .wr_data_in   (in_word),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (take),
    .rd_data_out  (fifo_word)
  );

  assign take                = !out_valid || lane_ready_in;
  assign lane_word_valid_out = out_valid;

  always_comb begin
    next_out_valid = take ? fifo_valid : out_valid;
    next_out_word  = (take && fifo_valid) ? fifo_word : out_word;
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      out_valid <= 1'b0;
      out_word  <= '0;
    end else begin
      out_valid <= next_out_valid;
      out_word  <= next_out_word;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  sequence s_stall;
    out_valid && !lane_ready_in;
  endsequence

  sequence s_word_held;
    out_valid && $stable(out_word);
  endsequence

  property p_hold_on_stall;
    s_stall |=> s_word_held;
  endproperty

  a_stalled_word_held: assert property (p_hold_on_stall)
    else $error("output word changed while stalled");

  a_empty_no_output: assert property (
    !out_valid && !fifo_valid |=> !out_valid)
    else $error("output valid without buffered data");

  for (genvar s = 0; s < SEG_COUNT; s++) begin : g_chk
    a_eop_needs_valid: assert property (
      !seg_valid_in[s] |-> !q_eop[s] && !q_err[s])
      else $error("end qualified without valid");

    a_err_needs_eop: assert property (
      seg_valid_in[s] && !seg_end_of_packet_in[s] |-> !q_err[s]
        && q_payload[s] == seg_payload_in[s])
      else $error("error taken outside end transfer");

    a_err_word_sub: assert property (
      q_err[s] |-> q_payload[s] == ERR_WORD
        && in_word[s*LANE_W + FLD_ERR])
      else $error("errored end word not replaced");

    a_out_err_clean: assert property (
      lane_word_valid_out && lane_err_word_out[s] |-> lane_payload_out[s] == ERR_WORD
        && lane_empty_out[s][2:0] == 3'h0 && !lane_fcs_check_en_out[s])
      else $error("errored output word not clean");

    a_fcs_per_packet: assert property (
      q_eop[s] |-> in_word[s*LANE_W + FLD_FCS_EN] == !seg_packet_error_in[s])
      else $error("frame check enable wrong at end");

    a_mty_mid_zero: assert property (
      !q_eop[s] |-> q_mty[s] == MTY_NONE)
      else $error("empty count leaked on non-final transfer");

    a_mty_low_zero: assert property (
      q_err[s] |-> q_mty[s][2:0] == 3'h0)
      else $error("low empty bits not cleared on errored end");

    a_mty_top_kept: assert property (
      q_eop[s] |-> q_mty[s][3] == seg_empty_byte_count_in[s][3])
      else $error("top empty bit not passed");

    a_invalid_is_null: assert property (
      !seg_valid_in[s] |-> in_word[s*LANE_W + FLD_MTY +: 9] == 9'h000)
      else $error("invalid segment carries control");
  end
endmodule // tspi_top

// [src/tspi_pkg.sv]
package tspi_pkg;
  // Segment geometry
  localparam int SEG_NUM      = 4;
  localparam int SEG_DATA_W   = 128;
  localparam int SEG_MTY_W    = 4;
  localparam int FIFO_DEPTH   = 32;

  // Field positions inside one stored lane word
  localparam int FLD_PAYLOAD  = 0;
  localparam int FLD_MTY      = 128;
  localparam int FLD_VALID    = 132;
  localparam int FLD_SOP      = 133;
  localparam int FLD_EOP      = 134;
  localparam int FLD_ERR      = 135;
  localparam int FLD_FCS_EN   = 136;
  localparam int LANE_W       = 137;

  // Error control character, repeated over the whole replaced word
  localparam logic [7:0]   ERR_CODE_BYTE = 8'hFE;
  localparam logic [127:0] ERR_WORD      = {16{ERR_CODE_BYTE}};

  // Errored end keeps only the top bit of the empty count
  localparam logic [3:0]   MTY_ERR_MASK  = 4'h8;
  localparam logic [3:0]   MTY_NONE      = 4'h0;
endpackage

// [dv/tspi_src.sv]
`timescale 1ns/100ps

module tspi_src import tspi_pkg::*; (
  input  wire logic                  core_clk_in,
  input  wire logic                  ready_in,
  output logic [3:0]                 valid_out,
  output logic [3:0]                 sop_out,
  output logic [3:0]                 eop_out,
  output logic [3:0]                 err_out,
  output logic [3:0][3:0]            mty_out,
  output logic [3:0][SEG_DATA_W-1:0] pay_out
);
  initial begin
    {valid_out, sop_out, eop_out, err_out, mty_out} = '0;
    pay_out = '0;
  end

  // Caller frames packets: start first, one end last, with empty counts on non-end segments too
  task automatic put(input logic [3:0] v, s, e, r, input logic [3:0][3:0] m,
                     input logic [7:0] b);
    int n;
    n = 0;
    @(posedge core_clk_in);
    valid_out <= v;
    sop_out <= s;
    eop_out <= e;
    err_out <= r;
    mty_out <= m;
    for (int i = 0; i < 4; i++) pay_out[i] <= {16{b + 8'(i)}};
    do @(posedge core_clk_in); while (ready_in !== 1'b1 && ++n < 100);
    // Released valid drops and the other lines turn inverted so stale values never look live
    valid_out <= '0;
    sop_out <= ~s;
    eop_out <= ~e;
    err_out <= ~r;
    mty_out <= ~m;
    pay_out <= ~pay_out;
  endtask
endmodule // tspi_src

// [dv/testbench.sv]
`timescale 1ns/100ps

module testbench import tspi_pkg::*;;
  typedef struct packed {
    logic [3:0] v, s, e, r, f;
    logic [15:0] m;
    logic [511:0] p;
  } tspi_obs_t;
  logic                 core_clk_in;
  logic                 srst_in = 1'b1;
  logic                 lane_ready_in = 1'b0;
  logic [3:0]           v, s, e, r, lv, ls, le, lr, lf;
  logic [3:0][3:0]      m, lm;
  logic [3:0][127:0]    p, lp;
  logic                 seg_ready_out, lane_word_valid_out;
  int                   n_errors = 0, cmp_count = 0, cycles = 0;
  tspi_obs_t            seen[$];

  tspi_src u_tspi_src (.core_clk_in(core_clk_in), .ready_in(seg_ready_out), .valid_out(v),
    .sop_out(s), .eop_out(e), .err_out(r), .mty_out(m), .pay_out(p));
  tspi_top #(.SEG_COUNT(4), .BUF_DEPTH(32)) u_tspi_top (.core_clk_in(core_clk_in),
    .srst_in(srst_in), .seg_valid_in(v), .seg_start_of_packet_in(s),
    .seg_end_of_packet_in(e), .seg_packet_error_in(r), .seg_empty_byte_count_in(m),
    .seg_payload_in(p), .seg_ready_out(seg_ready_out), .lane_ready_in(lane_ready_in),
    .lane_word_valid_out(lane_word_valid_out), .lane_valid_out(lv), .lane_start_out(ls),
    .lane_end_out(le), .lane_err_word_out(lr), .lane_fcs_check_en_out(lf),
    .lane_empty_out(lm), .lane_payload_out(lp));

  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end

  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (lane_word_valid_out === 1'b1 && lane_ready_in === 1'b1)
      seen.push_back({lv, ls, le, lr, lf, lm, lp});
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk_flag(input string nm, input logic ex, input logic got);
    cmp_count++;
    if (got !== ex) begin
      n_errors++;
      $display("BAD %s exp %b got %b", nm, ex, got);
    end
  endtask

  task automatic chk_word(input string nm, input tspi_obs_t ex, input tspi_obs_t got);
    cmp_count++;
    if (got !== ex) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask

  function automatic tspi_obs_t model(logic [3:0] vv, ss, ee, rr, logic [3:0][3:0] mm,
                                       logic [7:0] b);
    tspi_obs_t o;
    logic [3:0][3:0] em;
    logic [3:0][127:0] ep;
    o = {vv, vv & ss, vv & ee, vv & ee & rr, vv & ee & ~rr, 16'h0000, 512'h0};
    for (int i = 0; i < 4; i++) begin
      em[i] = !o.e[i] ? 4'h0 : o.r[i] ? {mm[i][3], 3'b000} : mm[i];
      ep[i] = o.r[i] ? {16{8'hFE}} : (vv[i] ? {16{b + 8'(i)}} : 128'h0);
    end
    o.m = em;
    o.p = ep;
    return o;
  endfunction

  // Payload of an invalid segment is don't-care, so it is masked out
  task automatic expect_word(input tspi_obs_t ex);
    tspi_obs_t got;
    int n;
    n = 0;
    while (seen.size() == 0 && n < 50) begin
      @(posedge core_clk_in);
      n++;
    end
    got = (seen.size() > 0) ? seen.pop_front() : 'x;
    for (int i = 0; i < 4; i++) got.p[i*128 +: 128] &= {128{ex.v[i]}};
    chk_word("lane word", ex, got);
  endtask

  task automatic send_check(input logic [3:0] vv, ss, ee, rr, input logic [3:0][3:0] mm,
                            input logic [7:0] b);
    u_tspi_src.put(vv, ss, ee, rr, mm, b);
    expect_word(model(vv, ss, ee, rr, mm, b));
  endtask

  task automatic plain_packet();
    send_check(4'hB, 4'h1, 4'hC, 4'h4, {4'h5, 4'h3, 4'h2, 4'h9}, 8'h10);
  endtask

  task automatic errored_ends();
    send_check(4'hF, 4'h3, 4'h9, 4'hB, {4'h7, 4'hC, 4'hB, 4'hF}, 8'h20);
    send_check(4'h1, 4'h1, 4'h1, 4'h0, {4'hE, 4'hE, 4'hE, 4'h7}, 8'h30);
  endtask

  task automatic fill_drain();
    int k;
    k = 0;
    @(posedge core_clk_in);
    lane_ready_in <= 1'b0;
    while (k < 40 && seg_ready_out === 1'b1) begin
      u_tspi_src.put(4'h1, 4'h1, 4'h1, 4'h0, '0, 8'(k));
      k++;
      #1;
    end
    // Buffer entries plus the output register hold the whole backlog
    chk_flag("fill depth", 1'b1, k == FIFO_DEPTH + 1);
    @(posedge core_clk_in);
    lane_ready_in <= 1'b1;
    for (int j = 0; j < k; j++) expect_word(model(4'h1, 4'h1, 4'h1, 4'h0, '0, 8'(j)));
  endtask

  initial begin
    repeat (19) @(posedge core_clk_in);
    chk_flag("valid in reset", 1'b0, lane_word_valid_out);
    chk_flag("ready in reset", 1'b0, seg_ready_out);
    @(posedge core_clk_in);
    srst_in <= 1'b0;
    lane_ready_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    chk_flag("ready after reset", 1'b1, seg_ready_out);
    plain_packet();
    errored_ends();
    fill_drain();
    repeat (10) @(posedge core_clk_in);
    chk_flag("idle cycles stored", 1'b0, seen.size() != 0);
    complete_run();
  end
endmodule // testbench
